// >>> asrp_host.sv
// host-side model of the converter serial port: pin levels and frame capture
`timescale 1ns/1ps
`default_nettype none
module asrp_host (
	// device pins
	input wire logic mclk,
	input wire logic cs_n,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic sck_pullup_en,
	input wire logic sdo_out,
	input wire logic sdo_oe,
	// resolved lines
	output logic sck_w,
	output logic sck_clk,
	output logic sdo_w,
	// host controls
	input wire logic host_drv,
	input wire logic ext_go,
	input wire logic clr,
	// captured frame
	output logic [23:0] frame,
	output int rises
);
	logic flt;
	logic sdo_h;
	initial
	begin
		flt = 1'b0;
		sdo_h = 1'b0;
		sck_clk = 1'b0;
		frame = 24'h000000;
		rises = 0;
	end
	// undriven lines change every cycle so no stale level survives
	always @(posedge mclk)
		flt <= ~flt;
	// host holding the line low through power-on or cs fall picks external clock
	assign sck_w = sck_oe ? sck_out : (host_drv ? sck_clk : (sck_pullup_en ? 1'b1 : flt));
	assign sdo_w = sdo_oe ? sdo_out : flt;
	// line level as it stood just before a clock edge that also moves sdo
	always @(sdo_w)
		sdo_h <= #1 sdo_w;
	// sample on rising sck, flag first
	always @(posedge sck_w or posedge clr)
	begin
		if (clr)
		begin
			frame <= 24'h000000;
			rises <= 0;
		end
		else if (!cs_n)
		begin
			frame <= {frame[22:0], sdo_h};
			rises <= rises + 1;
		end
	end
	// external clock idles low and runs only within a frame
	always @(posedge ext_go)
	begin
		repeat (24)
		begin
			#6 sck_clk = 1'b1;
			#6 sck_clk = 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> asrp_pkg.sv
// constants and types for the converter serial result port
package asrp_pkg;
	// frame layout: flag bit then result, most significant first
	localparam int FRAME_BITS = 24;
	localparam int RES_BITS = 23;
	localparam logic [4:0] LAST_RISE = 5'h17;
	localparam logic [4:0] FRAME_END = 5'h18;
	// system clock
	localparam int CLK_FREQ_KHZ = 25000;
	// status test delay on the internal oscillator
	localparam int TEST_DELAY_NS = 23000;
	localparam int TEST_CYCLES = (TEST_DELAY_NS * CLK_FREQ_KHZ + 999999) / 1000000;
	// status test delay on an external oscillator, in tenths of its period
	localparam int TEST_EOSC_TENTHS = 36;
	// power-on reset interval
	localparam int POR_TIME_US = 1000;
	localparam int POR_CYCLES = (POR_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
	// internal serial clock: 24 periods in 1.25 ms, half period rounded up
	localparam int SCK_HALF_NS = 26042;
	localparam int SCK_HALF_CYCLES = (SCK_HALF_NS * CLK_FREQ_KHZ + 999999) / 1000000;
	// conversion time on the internal oscillator
	localparam int CONV_TIME_MS = 160;
	localparam int CONV_CYCLES = CONV_TIME_MS * CLK_FREQ_KHZ;
	// default external oscillator frequency, arbitrary plain value
	localparam int EOSC_KHZ = 153;
	// abstract conversion core: result advances by this step each conversion
	localparam logic [22:0] RES_STEP = 23'h000101;
	// values after reset
	localparam logic [22:0] RES_RST = 23'h000000;
	localparam logic [31:0] TIMER_RST = 32'h00000000;
	localparam logic [4:0] RISE_RST = 5'h00;
	// pin synchroniser slots
	localparam int SYNC_W = 5;
	localparam int SY_CS = 0;
	localparam int SY_SCK = 1;
	localparam int SY_OSC = 2;
	localparam int SY_DONE = 3;
	localparam int SY_START = 4;
	localparam logic [4:0] SYNC_RST = 5'h03;
	// port states
	typedef enum logic [3:0] {
		ST_CONV = 4'b0001,
		ST_SLEEP = 4'b0010,
		ST_TEST = 4'b0100,
		ST_OUT = 4'b1000
	} asrp_state_t;
endpackage

// >>> asrp_port.sv
// serial result port of a delta-sigma converter, device side
// Notes on behaviour
// - at end of power-on interval sck is sampled; low picks external clock
// - two-wire external mode: sdo shows the done flag while converting and asleep
// - done flag reads 1 while converting, 0 once finished
// - result captured into the static shift register when the flag falls
// - sdo changes on falling sck edges; host samples on rising, flag first
// - external mode: 24th falling sck edge drives sdo high and starts converting
// - cs fall with sck high or floating picks internal single-cycle mode
// - sck pull-up is switched off whenever sck goes low after the power-on interval, unless cs rises in that cycle during a status test
// - internal single-cycle mode: sdo released while cs high
// - cs low in internal mode: sck driven high while converting, low once done; flag placed on sdo
// - flag 0 and cs low: output starts after the status test delay
// - cs rising before the delay ends returns to sleep, result kept
// - internal mode drives its own sck; frame spans 24 rising edges
// - after 24th rise: sdo high, sck held high, new conversion
// - cs rising mid-frame abandons the transfer and starts a conversion
// - cs rising during a status test re-enables the sck pull-up
// - continuous mode picked at end of power-on unless sck low; pull-up on
// - continuous mode: sck and sdo high converting, both low when done
// - continuous mode: sleep at least half an sck period, then clock out
// - continuous mode: after 24th rise sdo high, sck high until done
// - result sent most significant bit first after the flag
// - cs fall with sck low selects the external clock
`timescale 1ns/1ps
`default_nettype none
module asrp_port #(
	parameter int POR_CYCLES = asrp_pkg::POR_CYCLES,
	parameter int CONV_CYCLES = asrp_pkg::CONV_CYCLES,
	parameter int SCK_HALF = asrp_pkg::SCK_HALF_CYCLES,
	parameter int EXTERNAL_OSCILLATOR_FREQUENCY = asrp_pkg::EOSC_KHZ
) (
	// system
	input wire logic mclk,
	input wire logic rst_n,
	// chip select pin
	input wire logic cs_n,
	// serial clock pin, split into four signals
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	output logic sck_pullup_en,
	// external serial clock as link clock
	input wire logic sck_clk,
	// data output pin
	output logic sdo_out,
	output logic sdo_oe,
	// high when the oscillator select pin carries an external oscillator
	input wire logic ext_osc_in,
	// state seen by the system
	output logic eoc_n,
	output logic ext_mode,
	output logic [22:0] result_word
);
	localparam int EOSC_TEST_CYCLES = (asrp_pkg::TEST_EOSC_TENTHS * asrp_pkg::CLK_FREQ_KHZ
		+ 10 * EXTERNAL_OSCILLATOR_FREQUENCY - 1) / (10 * EXTERNAL_OSCILLATOR_FREQUENCY);

	asrp_pkg::asrp_state_t state_q;
	logic [31:0] timer_q;
	logic [31:0] por_cnt_q;
	logic por_done_q;
	logic [4:0] rise_q;
	logic sck_q;
	logic sdo_q;
	logic mode_ext_q;
	logic cont_q;
	logic pullup_q;
	logic [22:0] res_q;
	logic [22:0] shreg_q;
	logic link_run_q;
	logic cs_prev_q;
	logic sck_prev_q;
	logic [asrp_pkg::SYNC_W-1:0] sy1_q;
	logic [asrp_pkg::SYNC_W-1:0] sy2_q;
	logic [asrp_pkg::SYNC_W-1:0] sy3_q;
	logic [asrp_pkg::SYNC_W-1:0] filt_q;
	logic [asrp_pkg::SYNC_W-1:0] raw;
	// link domain
	logic [4:0] lcnt_q;
	logic lsdo_q;
	logic ldone_q;
	logic lstart_q;

	logic cs_f;
	logic sck_f;
	logic cs_fall;
	logic cs_rise;
	logic sel_ext;
	logic conv_end;
	logic half_tick;
	logic [31:0] wait_cycles;
	logic ext_active;

	// three-stage synchronisers; a change counts when stages two and three agree
	assign raw = {lstart_q, ldone_q, ext_osc_in, sck_in, cs_n};
	genvar gi;
	generate
		for (gi = 0; gi < asrp_pkg::SYNC_W; gi++)
		begin : g_sync
			always_ff @(posedge mclk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					sy1_q[gi] <= asrp_pkg::SYNC_RST[gi];
					sy2_q[gi] <= asrp_pkg::SYNC_RST[gi];
					sy3_q[gi] <= asrp_pkg::SYNC_RST[gi];
					filt_q[gi] <= asrp_pkg::SYNC_RST[gi];
				end
				else
				begin
					sy1_q[gi] <= raw[gi];
					sy2_q[gi] <= sy1_q[gi];
					sy3_q[gi] <= sy2_q[gi];
					if (sy2_q[gi] == sy3_q[gi])
					begin
						filt_q[gi] <= sy3_q[gi];
					end
				end
			end
		end
	endgenerate

	assign cs_f = filt_q[asrp_pkg::SY_CS];
	assign sck_f = filt_q[asrp_pkg::SY_SCK];
	assign cs_fall = cs_prev_q & ~cs_f & por_done_q;
	assign cs_rise = ~cs_prev_q & cs_f & por_done_q;
	assign sel_ext = cs_fall ? ~sck_f : mode_ext_q;
	assign conv_end = (state_q == asrp_pkg::ST_CONV) && por_done_q && (timer_q == 32'(CONV_CYCLES - 1));
	assign half_tick = (timer_q == 32'(SCK_HALF - 1));
	// continuous mode waits half an sck period, otherwise the status test delay
	assign wait_cycles = cont_q ? 32'(SCK_HALF) :
		(filt_q[asrp_pkg::SY_OSC] ? 32'(EOSC_TEST_CYCLES) : 32'(asrp_pkg::TEST_CYCLES));
	assign ext_active = mode_ext_q && (state_q == asrp_pkg::ST_OUT);

	// edge history of the filtered pins
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cs_prev_q <= 1'b1;
			sck_prev_q <= 1'b1;
		end
		else
		begin
			cs_prev_q <= cs_f;
			sck_prev_q <= sck_f;
		end
	end

	// power-on interval
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			por_cnt_q <= asrp_pkg::TIMER_RST;
			por_done_q <= 1'b0;
		end
		else if (!por_done_q)
		begin
			por_cnt_q <= por_cnt_q + 32'h00000001;
			if (por_cnt_q == 32'(POR_CYCLES - 1))
			begin
				por_done_q <= 1'b1;
			end
		end
	end

	// clock mode: picked at end of power-on and again at each cs fall
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_ext_q <= 1'b0;
			cont_q <= 1'b0;
		end
		else if (!por_done_q && por_cnt_q == 32'(POR_CYCLES - 1))
		begin
			mode_ext_q <= ~sck_f;
			cont_q <= sck_f;
		end
		else if (cs_fall)
		begin
			mode_ext_q <= sel_ext;
			cont_q <= 1'b0;
		end
	end

	// weak pull-up on sck
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pullup_q <= 1'b1;
		end
		else if (!por_done_q)
		begin
			pullup_q <= 1'b1;
		end
		else if (cs_rise && state_q == asrp_pkg::ST_TEST)
		begin
			pullup_q <= 1'b1;
		end
		else if (sck_prev_q && !sck_f)
		begin
			pullup_q <= 1'b0;
		end
		else if (sck_f)
		begin
			pullup_q <= 1'b1;
		end
	end

	// abstract conversion core and static shift register
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			res_q <= asrp_pkg::RES_RST;
			shreg_q <= asrp_pkg::RES_RST;
		end
		else if (conv_end)
		begin
			res_q <= res_q + asrp_pkg::RES_STEP;
			shreg_q <= res_q + asrp_pkg::RES_STEP;
		end
	end

	// main sequence, internal sck divider and sdo
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= asrp_pkg::ST_CONV;
			timer_q <= asrp_pkg::TIMER_RST;
			rise_q <= asrp_pkg::RISE_RST;
			sck_q <= 1'b1;
			sdo_q <= 1'b1;
		end
		else if (!por_done_q)
		begin
			timer_q <= asrp_pkg::TIMER_RST;
		end
		else
		begin
			timer_q <= timer_q + 32'h00000001;
			case (state_q)
				asrp_pkg::ST_CONV:
				begin
					sck_q <= 1'b1;
					sdo_q <= 1'b1;
					if (conv_end)
					begin
						timer_q <= asrp_pkg::TIMER_RST;
						sck_q <= 1'b0;
						sdo_q <= 1'b0;
						if (cs_f)
						begin
							state_q <= asrp_pkg::ST_SLEEP;
						end
						else if (mode_ext_q)
						begin
							state_q <= asrp_pkg::ST_OUT;
						end
						else
						begin
							state_q <= asrp_pkg::ST_TEST;
						end
					end
				end
				asrp_pkg::ST_SLEEP:
				begin
					sck_q <= 1'b0;
					sdo_q <= 1'b0;
					timer_q <= asrp_pkg::TIMER_RST;
					rise_q <= asrp_pkg::RISE_RST;
					if (cs_fall)
					begin
						state_q <= sel_ext ? asrp_pkg::ST_OUT : asrp_pkg::ST_TEST;
					end
				end
				asrp_pkg::ST_TEST:
				begin
					sck_q <= 1'b0;
					sdo_q <= 1'b0;
					rise_q <= asrp_pkg::RISE_RST;
					if (cs_rise)
					begin
						state_q <= asrp_pkg::ST_SLEEP;
					end
					else if (timer_q == wait_cycles - 32'h00000001)
					begin
						timer_q <= asrp_pkg::TIMER_RST;
						state_q <= asrp_pkg::ST_OUT;
					end
				end
				asrp_pkg::ST_OUT:
				begin
					if (mode_ext_q)
					begin
						if (cs_rise)
						begin
							// a transfer that has begun is abandoned for a new conversion
							state_q <= filt_q[asrp_pkg::SY_START] ? asrp_pkg::ST_CONV : asrp_pkg::ST_SLEEP;
							timer_q <= asrp_pkg::TIMER_RST;
						end
						else if (filt_q[asrp_pkg::SY_DONE])
						begin
							state_q <= asrp_pkg::ST_CONV;
							timer_q <= asrp_pkg::TIMER_RST;
							sdo_q <= 1'b1;
						end
					end
					else if (cs_rise)
					begin
						timer_q <= asrp_pkg::TIMER_RST;
						if (rise_q != asrp_pkg::RISE_RST || sck_q)
						begin
							state_q <= asrp_pkg::ST_CONV;
							sdo_q <= 1'b1;
							sck_q <= 1'b1;
						end
						else
						begin
							state_q <= asrp_pkg::ST_SLEEP;
						end
					end
					else if (half_tick)
					begin
						timer_q <= asrp_pkg::TIMER_RST;
						if (!sck_q)
						begin
							sck_q <= 1'b1;
							rise_q <= rise_q + 5'h01;
							if (rise_q == asrp_pkg::LAST_RISE)
							begin
								state_q <= asrp_pkg::ST_CONV;
								sdo_q <= 1'b1;
							end
						end
						else
						begin
							sck_q <= 1'b0;
							sdo_q <= shreg_q[5'(asrp_pkg::FRAME_BITS - 1) - rise_q];
						end
					end
				end
				default:
				begin
					state_q <= asrp_pkg::ST_CONV;
				end
			endcase
		end
	end

	// release of the link-side logic: held in reset unless a frame is armed
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link_run_q <= 1'b0;
		end
		else
		begin
			link_run_q <= ext_active && !cs_f && !cs_rise && !filt_q[asrp_pkg::SY_DONE];
		end
	end

	// link domain: bits change on falling edges of the host clock
	always_ff @(negedge sck_clk or negedge link_run_q)
	begin
		if (!link_run_q)
		begin
			lcnt_q <= asrp_pkg::RISE_RST;
			lsdo_q <= 1'b0;
			ldone_q <= 1'b0;
			lstart_q <= 1'b0;
		end
		else if (lcnt_q != asrp_pkg::FRAME_END)
		begin
			lcnt_q <= lcnt_q + 5'h01;
			lstart_q <= 1'b1;
			if (lcnt_q == asrp_pkg::LAST_RISE)
			begin
				lsdo_q <= 1'b1;
				ldone_q <= 1'b1;
			end
			else
			begin
				lsdo_q <= shreg_q[5'(asrp_pkg::RES_BITS - 1) - lcnt_q];
			end
		end
	end

	// pins
	assign sdo_out = ext_active ? lsdo_q : sdo_q;
	assign sdo_oe = por_done_q && !cs_f;
	assign sck_out = sck_q;
	assign sck_oe = por_done_q && !mode_ext_q && !cs_f;
	assign sck_pullup_en = pullup_q;
	assign eoc_n = (state_q == asrp_pkg::ST_CONV);
	assign ext_mode = mode_ext_q;
	assign result_word = shreg_q;

	sequence s_last_rise;
		(state_q == asrp_pkg::ST_OUT) && !mode_ext_q && half_tick && !sck_q && !cs_rise
			&& rise_q == asrp_pkg::LAST_RISE;
	endsequence

	sequence s_frame_close;
		(state_q == asrp_pkg::ST_CONV) && sck_q && sdo_q;
	endsequence

	a_sdo_release_cs: assert property (@(posedge mclk) disable iff (!rst_n) cs_f |-> !sdo_oe)
		else $error("sdo driven while cs high");
	a_flag_converting: assert property (@(posedge mclk) disable iff (!rst_n)
		(por_done_q && state_q == asrp_pkg::ST_CONV && $past(state_q) == asrp_pkg::ST_CONV) |-> sdo_out)
		else $error("flag not high during conversion");
	a_capture_result: assert property (@(posedge mclk) disable iff (!rst_n)
		conv_end |=> (shreg_q == res_q && shreg_q == $past(res_q) + asrp_pkg::RES_STEP))
		else $error("result not captured at flag fall");
	a_test_abort: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_q == asrp_pkg::ST_TEST && cs_rise) |=> (state_q == asrp_pkg::ST_SLEEP && $stable(shreg_q)))
		else $error("status test abort did not sleep");
	a_frame_abort: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_q == asrp_pkg::ST_OUT && !mode_ext_q && cs_rise && rise_q != asrp_pkg::RISE_RST)
		|=> state_q == asrp_pkg::ST_CONV)
		else $error("frame not abandoned on cs rise");
	a_frame_end: assert property (@(posedge mclk) disable iff (!rst_n) s_last_rise |=> s_frame_close)
		else $error("frame end did not start conversion");
	a_cont_done: assert property (@(posedge mclk) disable iff (!rst_n)
		(conv_end && cont_q && !cs_f) |=> (!sck_q && !sdo_q) [*2])
		else $error("continuous completion not shown low");
	a_por_pullup: assert property (@(posedge mclk) disable iff (!rst_n) !por_done_q |-> sck_pullup_en)
		else $error("pull-up off during power-on");
	a_test_sck_low: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_q == asrp_pkg::ST_TEST && !cs_f && !mode_ext_q) |-> (sck_oe && !sck_out && !sdo_out))
		else $error("status test pins wrong");
	a_test_wait: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_q == asrp_pkg::ST_TEST && $past(state_q) != asrp_pkg::ST_TEST && !cont_q)
		|-> (state_q == asrp_pkg::ST_TEST) [*8])
		else $error("output began before status test delay");
	a_link_busy: assert property (@(posedge mclk) disable iff (!rst_n)
		(link_run_q && lcnt_q == asrp_pkg::FRAME_END) |-> (lsdo_q && ldone_q))
		else $error("24th falling edge did not show busy");
endmodule
`default_nettype wire

// >>> asrp_port_tb.sv
// self-checking bench for the converter serial result port
`timescale 1ns/1ps
`default_nettype none
module asrp_port_tb;
	localparam int POR = 20;
	localparam int CONV = 200;
	localparam int HALF = 8;
	localparam int LIM = asrp_pkg::TEST_CYCLES + 48 * HALF + 100;
	typedef struct {int n_rise; logic exp_eoc;} asrp_row_t;
	logic mclk, rst_n, cs_n, host_drv, ext_go, clr;
	logic sck_w, sck_clk, sdo_w, sck_out, sck_oe, sck_pullup_en, sdo_out, sdo_oe, eoc_n, ext_mode;
	logic [22:0] result_word;
	logic [23:0] frame;
	int rises, err_count, compares, ncv, took, k;
	asrp_row_t rows [3];

	asrp_port #(.POR_CYCLES(POR), .CONV_CYCLES(CONV), .SCK_HALF(HALF)) u_asrp_port (
		.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe),
		.sck_pullup_en(sck_pullup_en), .sck_clk(sck_clk), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
		.ext_osc_in(1'b0), .eoc_n(eoc_n), .ext_mode(ext_mode), .result_word(result_word));
	asrp_host u_asrp_host (
		.mclk(mclk), .cs_n(cs_n), .sck_out(sck_out), .sck_oe(sck_oe), .sck_pullup_en(sck_pullup_en),
		.sdo_out(sdo_out), .sdo_oe(sdo_oe), .sck_w(sck_w), .sck_clk(sck_clk), .sdo_w(sdo_w),
		.host_drv(host_drv), .ext_go(ext_go), .clr(clr), .frame(frame), .rises(rises));

	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// completed conversions since reset
	always @(negedge eoc_n or negedge rst_n)
		if (!rst_n)
			ncv = 0;
		else
			ncv = ncv + 1;

	function automatic logic [23:0] exp_frame();
		exp_frame = {1'b0, asrp_pkg::RES_STEP * 23'(ncv)};
	endfunction
	task automatic summarize();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input logic [23:0] got, input logic [23:0] exp, input string msg);
		compares++;
		if (got !== exp)
		begin
			$display("[ERR] %0t %s", $time, msg);
			err_count++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic give_up(input string msg);
		$display("[ERR] %0t timeout %s", $time, msg);
		err_count++;
		summarize();
	endtask
	task automatic wait_eoc(input logic v);
		int i;
		for (i = 0; i < CONV + POR + 100 && eoc_n !== v; i++)
			cyc(1);
		if (eoc_n !== v)
			give_up("done flag");
	endtask
	task automatic wait_rise(input int n, output int t);
		for (t = 0; t < LIM && rises < n; t++)
			cyc(1);
		if (rises < n)
			give_up("sck rise");
	endtask
	task automatic host_clr();
		clr = 1'b1;
		#1 clr = 1'b0;
	endtask

	initial
	begin
		rst_n = 1'b0;
		cs_n = 1'b0;
		host_drv = 1'b0;
		ext_go = 1'b0;
		clr = 1'b0;
		err_count = 0;
		compares = 0;
		rows[0] = '{0, 1'b0};
		rows[1] = '{5, 1'b1};
		rows[2] = '{24, 1'b1};
		cyc(5);
		check(sck_pullup_en, 1'b1, "pull-up in reset");
		rst_n = 1'b1;
		host_clr();
		cyc(POR + 8);
		check(ext_mode, 1'b0, "continuous mode chosen");
		check(sck_w & sdo_w, 1'b1, "levels while converting");
		wait_eoc(1'b0);
		cyc(1);
		check(sck_w | sdo_w, 1'b0, "levels at completion");
		wait_rise(1, took);
		check(took >= HALF - 1, 1'b1, "sleep before output");
		wait_rise(24, took);
		check(frame, exp_frame(), "continuous frame");
		cyc(HALF + 2);
		check({sck_w, sdo_w, eoc_n}, 3'h7, "after continuous frame");
		cs_n = 1'b1;
		cyc(8);
		check(sdo_oe, 1'b0, "sdo released");
		for (k = 0; k < 3; k++)
		begin
			wait_eoc(1'b0);
			host_clr();
			cs_n = 1'b0;
			cyc(8);
			check({sck_oe, sck_out, sdo_out}, 3'h4, "status test levels");
			if (rows[k].n_rise > 0)
				wait_rise(rows[k].n_rise, took);
			else
				cyc(20);
			if (rows[k].n_rise == 24)
			begin
				cyc(2);
				check({sck_w, sdo_w}, 2'h3, "after frame");
				check(frame, exp_frame(), "single-cycle frame");
			end
			cs_n = 1'b1; // raised with sck low in the status-test row, high in the other two rows
			cyc(12);
			check(eoc_n, rows[k].exp_eoc, "state after cs rise");
			if (rows[k].n_rise == 0)
			begin
				check(result_word, exp_frame(), "result kept");
				check(sck_pullup_en, 1'b1, "pull-up back on");
			end
		end
		// status test started during a conversion
		host_clr();
		cs_n = 1'b0;
		cyc(8);
		check({sck_oe, sdo_out}, 2'h3, "busy flag on sdo");
		wait_eoc(1'b0);
		wait_rise(1, took);
		check(took >= asrp_pkg::TEST_CYCLES - 2 && took <= asrp_pkg::TEST_CYCLES + HALF + 8, 1'b1, "test delay");
		wait_rise(24, took);
		check(frame, exp_frame(), "frame after test delay");
		// second power-on with sck held low: external two-wire mode
		host_drv = 1'b1;
		rst_n = 1'b0;
		cyc(5);
		rst_n = 1'b1;
		host_clr();
		cyc(POR + 8);
		check({ext_mode, sdo_w}, 2'h3, "external mode, busy");
		wait_eoc(1'b0);
		cyc(10);
		check(sdo_w, 1'b0, "done flag on sdo");
		ext_go = 1'b1;
		wait_rise(24, took);
		ext_go = 1'b0;
		cyc(2);
		check(frame, exp_frame(), "external frame");
		check(sdo_w, 1'b1, "busy after last fall");
		cyc(10);
		check(eoc_n, 1'b1, "new conversion");
		summarize();
	end
endmodule
`default_nettype wire
